// >>> shared/iexs_pkg.sv
// iexs_pkg: constants and types for the instruction execution subset block
// assumes: one 100 MHz clock, synchronous active-low reset
package iexs_pkg;

  // ----------------------------------------------------------------
  // operation codes presented on the op port
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    IEXS_OP_NOP     = 5'h00,
    IEXS_OP_BCDADJ  = 5'h01,
    IEXS_OP_DEC     = 5'h02,
    IEXS_OP_DECA    = 5'h03,
    IEXS_OP_INC     = 5'h04,
    IEXS_OP_INCA    = 5'h05,
    IEXS_OP_HALT    = 5'h06,
    IEXS_OP_JMP     = 5'h07,
    IEXS_OP_MOV_AM  = 5'h08,
    IEXS_OP_MOV_AX  = 5'h09,
    IEXS_OP_MOV_MA  = 5'h0A,
    IEXS_OP_OR_AM   = 5'h0B,
    IEXS_OP_OR_AX   = 5'h0C,
    IEXS_OP_ORM     = 5'h0D,
    IEXS_OP_RET     = 5'h0E,
    IEXS_OP_RETV    = 5'h0F,
    IEXS_OP_IRQRET  = 5'h10,
    IEXS_OP_RL      = 5'h11,
    IEXS_OP_RLA     = 5'h12,
    IEXS_OP_RLCM    = 5'h13,
    IEXS_OP_RLCA    = 5'h14
  } iexs_op_t;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    IEXS_ST_IDLE   = 2'b00,
    IEXS_ST_RET2   = 2'b01,
    IEXS_ST_HALTED = 2'b10
  } iexs_state_t;

  // ----------------------------------------------------------------
  // widths, positions, reset values
  // ----------------------------------------------------------------
  localparam int PC_W            = 13;
  localparam int MADDR_W         = 8;
  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam logic [3:0] BCD_FIX = 4'h6;
  localparam int IRQ_EN_BIT      = 0;
  localparam logic [PC_W-1:0] PC_RST   = 13'h0000;
  localparam logic [7:0] WREG_RST      = 8'h00;
  localparam logic [7:0] IRQCTL_RST    = 8'h00;
  localparam logic [7:0] WATCHDOG_RST  = 8'h00;
  localparam logic       FLAG_RST      = 1'b0;
  localparam logic [PC_W-1:0] PC_STEP  = 13'h0001;

  // register index map of the software port
  localparam logic [2:0] RIDX_WREG   = 3'h0;
  localparam logic [2:0] RIDX_STATUS = 3'h1;
  localparam logic [2:0] RIDX_IRQCTL = 3'h2;
  localparam logic [2:0] RIDX_PCLO   = 3'h3;
  localparam logic [2:0] RIDX_PCHI   = 3'h4;
  localparam logic [2:0] RIDX_WATCHDOG = 3'h5;
  // status byte field positions
  localparam int ST_CARRY = 0;
  localparam int ST_HALF  = 1;
  localparam int ST_ZERO  = 2;
  localparam int ST_TOUT  = 4;
  localparam int ST_PDOWN = 5;

endpackage : iexs_pkg

// >>> rtl/iexs_bcd_adj.sv
// iexs_bcd_adj: combinational decimal adjust of one byte
// assumes: inputs come from the core's own registers
`timescale 1ns/100ps
module iexs_bcd_adj (
  // operand and flags
  input  wire logic [7:0] wreg_val,
  input  wire logic       half_carry_flag,
  input  wire logic       carry_in,
  // adjusted result
  output logic      [7:0] adj_val,
  output logic            carry_out
);
  import iexs_pkg::*;

  logic       interim_nibble_carry;
  logic [3:0] lo_nib;
  logic [4:0] hi_sum;
  logic [3:0] lo_sum;

  always_comb begin
    lo_sum = wreg_val[3:0] + BCD_FIX;
    if ((wreg_val[3:0] > BCD_MAX) || half_carry_flag) begin
      lo_nib               = lo_sum;
      // a set half-carry means the low fix already wrapped once: no second carry up
      interim_nibble_carry = ~half_carry_flag;
    end else begin
      lo_nib               = wreg_val[3:0];
      interim_nibble_carry = 1'b0;
    end
    hi_sum = {1'b0, wreg_val[7:4]} + {4'h0, interim_nibble_carry};
    if ((hi_sum > {1'b0, BCD_MAX}) || carry_in) begin
      adj_val   = {hi_sum[3:0] + BCD_FIX, lo_nib};
      carry_out = 1'b1;
    end else begin
      adj_val   = {hi_sum[3:0], lo_nib};
      carry_out = carry_in;
    end
  end

endmodule // iexs_bcd_adj

// >>> rtl/iexs_core.sv
// iexs_core: execution datapath for a subset of an 8-bit core's instructions
// assumes: one op per issue pulse, memory operand valid beside it,
// stack top supplied by the stack block, memory write taken by the RAM
//
// Functional notes
// - low nibble above 9 or half-carry: add 6
// - high nibble plus interim carry, fix and set carry
// - decimal adjust writes memory, only carry changes
// - in-place inc/dec writes memory, zero flag only
// - accumulator inc/dec writes work register, zero only
// - halt stops execution, keeps state, pc plus one
// - halt clears watchdog, sets powerdown, clears timeout
// - jump loads pc bits 0-12 from instruction
// - moves copy bytes, no flags change
// - no-operation only advances pc by one
// - or into register or memory, zero only
// - return reloads pc from stack, two cycles
// - return-with-value loads pc and work register
// - interrupt return reloads pc, sets global enable
// - rotate left, bit 7 into bit 0
// - rotate through carry, carry updated only
`timescale 1ns/100ps
module iexs_core (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  // instruction issue
  input  wire logic                        issue,
  input  wire iexs_pkg::iexs_op_t          op,
  input  wire logic [7:0]                  imm,
  input  wire logic [iexs_pkg::PC_W-1:0]   jump_addr,
  input  wire logic [7:0]                  mem_rdata,
  input  wire logic [iexs_pkg::PC_W-1:0]   stack_top,
  input  wire logic                        wake,
  // issue acceptance
  output logic                             busy,
  // data memory write
  output logic                             mem_we,
  output logic [7:0]                       mem_wdata,
  // core status
  output logic [iexs_pkg::PC_W-1:0]        pc,
  output logic                             stack_pop,
  output logic                             sys_clk_en,
  output logic                             watchdog_clear,
  // software register port
  input  wire logic [2:0]                  reg_addr,
  input  wire logic [7:0]                  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic [7:0]                       reg_rdata
);
  import iexs_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  iexs_state_t     state_q;
  logic [7:0]      work_register_q;
  logic [PC_W-1:0] pc_q;
  logic            carry_q;
  logic            half_carry_flag_q;
  logic            zero_q;
  logic            powerdown_flag_q;
  logic            timeout_flag_q;
  logic [7:0]      irq_control_reg_q;
  logic [7:0]      watchdog_counter_q;
  logic [7:0]      prescaler_q;
  logic            mem_we_q;
  logic [7:0]      mem_wdata_q;
  logic            stack_pop_q;
  logic            watchdog_clear_q;
  logic [7:0]      reg_rdata_q;

  logic            take;
  logic [7:0]      bcd_val;
  logic            bcd_carry;
  logic [7:0]      res;
  logic            wr_mem;
  logic            wr_acc;
  logic            upd_zero;
  logic            new_carry;
  logic            upd_carry;

  function automatic logic [7:0] rol8(input logic [7:0] v, input logic lsb);
    rol8 = {v[6:0], lsb};
  endfunction

  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == 8'h00);
  endfunction

  assign take = issue && (state_q == IEXS_ST_IDLE);

  iexs_bcd_adj u_bcd (
    .wreg_val        (work_register_q),
    .half_carry_flag (half_carry_flag_q),
    .carry_in        (carry_q),
    .adj_val         (bcd_val),
    .carry_out       (bcd_carry)
  );

  // ----------------------------------------------------------------
  // operation decode
  // ----------------------------------------------------------------
  always_comb begin
    res       = work_register_q;
    wr_mem    = 1'b0;
    wr_acc    = 1'b0;
    upd_zero  = 1'b0;
    upd_carry = 1'b0;
    new_carry = carry_q;
    case (op)
      IEXS_OP_BCDADJ: begin
        res = bcd_val; wr_mem = 1'b1; upd_carry = 1'b1; new_carry = bcd_carry;
      end
      IEXS_OP_DEC: begin
        res = mem_rdata - 8'h01; wr_mem = 1'b1; upd_zero = 1'b1;
      end
      IEXS_OP_INC: begin
        res = mem_rdata + 8'h01; wr_mem = 1'b1; upd_zero = 1'b1;
      end
      IEXS_OP_DECA: begin
        res = mem_rdata - 8'h01; wr_acc = 1'b1; upd_zero = 1'b1;
      end
      IEXS_OP_INCA: begin
        res = mem_rdata + 8'h01; wr_acc = 1'b1; upd_zero = 1'b1;
      end
      IEXS_OP_MOV_AM: begin
        res = mem_rdata; wr_acc = 1'b1;
      end
      IEXS_OP_MOV_AX: begin
        res = imm; wr_acc = 1'b1;
      end
      IEXS_OP_MOV_MA: begin
        res = work_register_q; wr_mem = 1'b1;
      end
      IEXS_OP_OR_AM: begin
        res = work_register_q | mem_rdata; wr_acc = 1'b1; upd_zero = 1'b1;
      end
      IEXS_OP_OR_AX: begin
        res = work_register_q | imm; wr_acc = 1'b1; upd_zero = 1'b1;
      end
      IEXS_OP_ORM: begin
        res = work_register_q | mem_rdata; wr_mem = 1'b1; upd_zero = 1'b1;
      end
      IEXS_OP_RETV: begin
        res = imm; wr_acc = 1'b1;
      end
      IEXS_OP_RL: begin
        res = rol8(mem_rdata, mem_rdata[7]); wr_mem = 1'b1;
      end
      IEXS_OP_RLA: begin
        res = rol8(mem_rdata, mem_rdata[7]); wr_acc = 1'b1;
      end
      IEXS_OP_RLCM: begin
        res = rol8(mem_rdata, carry_q); wr_mem = 1'b1;
        upd_carry = 1'b1; new_carry = mem_rdata[7];
      end
      IEXS_OP_RLCA: begin
        res = rol8(mem_rdata, carry_q); wr_acc = 1'b1;
        upd_carry = 1'b1; new_carry = mem_rdata[7];
      end
      default: begin
        res = work_register_q;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer and program counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q     <= IEXS_ST_IDLE;
      pc_q        <= PC_RST;
      stack_pop_q <= 1'b0;
    end else begin
      stack_pop_q <= 1'b0;
      case (state_q)
        IEXS_ST_IDLE: begin
          if (take) begin
            case (op)
              IEXS_OP_JMP: pc_q <= jump_addr;
              IEXS_OP_RET, IEXS_OP_RETV, IEXS_OP_IRQRET: begin
                state_q <= IEXS_ST_RET2;
              end
              IEXS_OP_HALT: begin
                pc_q    <= pc_q + PC_STEP;
                state_q <= IEXS_ST_HALTED;
              end
              default: pc_q <= pc_q + PC_STEP;
            endcase
          end
        end
        IEXS_ST_RET2: begin
          // second machine cycle of every return form
          pc_q        <= stack_top;
          stack_pop_q <= 1'b1;
          state_q     <= IEXS_ST_IDLE;
        end
        IEXS_ST_HALTED: begin
          if (wake) begin
            state_q <= IEXS_ST_IDLE;
          end
        end
        default: state_q <= IEXS_ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // work register and data memory write
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      work_register_q <= WREG_RST;
      mem_we_q        <= 1'b0;
      mem_wdata_q     <= 8'h00;
    end else begin
      mem_we_q <= take && wr_mem;
      if (take && wr_mem) begin
        mem_wdata_q <= res;
      end
      if (take && wr_acc) begin
        work_register_q <= res;
      end else if (reg_wr && (reg_addr == RIDX_WREG)) begin
        work_register_q <= reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // status flags; executed ops win over software writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      carry_q           <= FLAG_RST;
      half_carry_flag_q <= FLAG_RST;
      zero_q            <= FLAG_RST;
      powerdown_flag_q  <= FLAG_RST;
      timeout_flag_q    <= FLAG_RST;
    end else if (take && (op == IEXS_OP_HALT)) begin
      powerdown_flag_q <= 1'b1;
      timeout_flag_q   <= 1'b0;
    end else if (take && (upd_carry || upd_zero)) begin
      if (upd_carry) begin
        carry_q <= new_carry;
      end
      if (upd_zero) begin
        zero_q <= is_zero(res);
      end
    end else if (reg_wr && (reg_addr == RIDX_STATUS)) begin
      carry_q           <= reg_wdata[ST_CARRY];
      half_carry_flag_q <= reg_wdata[ST_HALF];
      zero_q            <= reg_wdata[ST_ZERO];
      timeout_flag_q    <= reg_wdata[ST_TOUT];
      powerdown_flag_q  <= reg_wdata[ST_PDOWN];
    end
  end

  // ----------------------------------------------------------------
  // interrupt control and watchdog
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_control_reg_q <= IRQCTL_RST;
    end else if (take && (op == IEXS_OP_IRQRET)) begin
      irq_control_reg_q[IRQ_EN_BIT] <= 1'b1;
    end else if (reg_wr && (reg_addr == RIDX_IRQCTL)) begin
      irq_control_reg_q <= reg_wdata;
    end
  end

  // simple model that counts except while halted; the real watchdog sits elsewhere
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      watchdog_counter_q <= WATCHDOG_RST;
      prescaler_q        <= WATCHDOG_RST;
      watchdog_clear_q   <= 1'b0;
    end else begin
      watchdog_clear_q <= take && (op == IEXS_OP_HALT);
      if (take && (op == IEXS_OP_HALT)) begin
        watchdog_counter_q <= WATCHDOG_RST;
        prescaler_q        <= WATCHDOG_RST;
      end else if (state_q != IEXS_ST_HALTED) begin
        prescaler_q <= prescaler_q + 8'h01;
        if (prescaler_q == 8'hFF) begin
          watchdog_counter_q <= watchdog_counter_q + 8'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        RIDX_WREG:   reg_rdata_q <= work_register_q;
        RIDX_STATUS: reg_rdata_q <= {2'b00, powerdown_flag_q, timeout_flag_q, 1'b0,
                                     zero_q, half_carry_flag_q, carry_q};
        RIDX_IRQCTL: reg_rdata_q <= irq_control_reg_q;
        RIDX_PCLO:   reg_rdata_q <= pc_q[7:0];
        RIDX_PCHI:   reg_rdata_q <= {3'b000, pc_q[PC_W-1:8]};
        RIDX_WATCHDOG: reg_rdata_q <= watchdog_counter_q;
        default:     reg_rdata_q <= 8'h00;
      endcase
    end else begin
      reg_rdata_q <= 8'h00;
    end
  end

  // halted core holds sys_clk_en low until wake; it still samples wake on clk
  assign sys_clk_en = (state_q != IEXS_ST_HALTED);
  assign busy       = (state_q != IEXS_ST_IDLE);
  assign mem_we     = mem_we_q;
  assign mem_wdata  = mem_wdata_q;
  assign pc         = pc_q;
  assign stack_pop  = stack_pop_q;
  assign watchdog_clear = watchdog_clear_q;
  assign reg_rdata  = reg_rdata_q;

endmodule // iexs_core

// >>> testbench/iexs_core_props.sv
// iexs_core_props: concurrent checks on the execution core's ports
// assumes: bound onto iexs_core, single clock, synchronous reset
`timescale 1ns/100ps
module iexs_core_props (
  // clock and reset
  input wire logic                      clk,
  input wire logic                      rst_n,
  // issue side
  input wire logic                      issue,
  input wire iexs_pkg::iexs_op_t        op,
  input wire logic [iexs_pkg::PC_W-1:0] jump_addr,
  input wire logic [7:0]                mem_rdata,
  input wire logic [iexs_pkg::PC_W-1:0] stack_top,
  input wire logic                      wake,
  // results
  input wire logic                      busy,
  input wire logic                      mem_we,
  input wire logic [7:0]                mem_wdata,
  input wire logic [iexs_pkg::PC_W-1:0] pc,
  input wire logic                      stack_pop,
  input wire logic                      sys_clk_en,
  input wire logic                      watchdog_clear
);
  import iexs_pkg::*;
  logic take;
  assign take = issue && !busy;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_mem_write_ops: assert property (
    take && op inside {IEXS_OP_BCDADJ, IEXS_OP_DEC, IEXS_OP_INC, IEXS_OP_MOV_MA, IEXS_OP_ORM, IEXS_OP_RL,
    IEXS_OP_RLCM} |=> mem_we) else $error("memory op gave no write");
  chk_acc_no_write: assert property (
    take && op inside {IEXS_OP_DECA, IEXS_OP_INCA, IEXS_OP_MOV_AM, IEXS_OP_MOV_AX, IEXS_OP_OR_AM, IEXS_OP_OR_AX,
    IEXS_OP_RLA, IEXS_OP_RLCA, IEXS_OP_NOP, IEXS_OP_JMP} |=> !mem_we) else $error("register op wrote memory");
  chk_dec_value: assert property (
    take && op == IEXS_OP_DEC |=> mem_wdata == $past(mem_rdata) - 8'h01) else $error("decrement value wrong");
  chk_rotate_value: assert property (
    take && op == IEXS_OP_RL |=> mem_wdata == {$past(mem_rdata[6:0]), $past(mem_rdata[7])})
    else $error("rotate value wrong");
  chk_jump_target: assert property (
    take && op == IEXS_OP_JMP |=> pc == $past(jump_addr)) else $error("jump target wrong");
  chk_nop_step: assert property (
    take && op == IEXS_OP_NOP |=> pc == $past(pc) + PC_STEP) else $error("nop pc step wrong");
  chk_return_two: assert property (
    take && op inside {IEXS_OP_RET, IEXS_OP_RETV, IEXS_OP_IRQRET}
    |=> busy ##1 (!busy && stack_pop && pc == $past(stack_top))) else $error("return sequence wrong");
  chk_halt_entry: assert property (
    take && op == IEXS_OP_HALT |=> !sys_clk_en && busy && watchdog_clear && pc == $past(pc) + PC_STEP)
    else $error("halt entry wrong");
  chk_halt_hold: assert property (
    !sys_clk_en && !wake |=> !sys_clk_en && !mem_we && $stable(pc)) else $error("halted core moved");
endmodule // iexs_core_props

bind iexs_core iexs_core_props iexs_core_props_inst (
  .clk(clk), .rst_n(rst_n), .issue(issue), .op(op), .jump_addr(jump_addr), .mem_rdata(mem_rdata),
  .stack_top(stack_top), .wake(wake), .busy(busy), .mem_we(mem_we), .mem_wdata(mem_wdata), .pc(pc),
  .stack_pop(stack_pop), .sys_clk_en(sys_clk_en), .watchdog_clear(watchdog_clear)
);

// >>> testbench/instruction_exec_subset_bench.sv
// instruction_exec_subset_bench: directed op sequences with port-level checks
// assumes: iexs_core with the props checker bound to it
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module instruction_exec_subset_bench;
  import iexs_pkg::*;
  logic            clk, rst_n, issue, wake, busy, mem_we, stack_pop, sys_clk_en, watchdog_clear;
  logic            reg_wr, reg_rd, got_we;
  iexs_op_t        op;
  logic [7:0]      imm, mem_rdata, mem_wdata, reg_wdata, reg_rdata, got_wd, v;
  logic [PC_W-1:0] jump_addr, stack_top, pc, pc_exp;
  logic [2:0]      reg_addr;
  int              num_errors, n_checks, cyc;

  iexs_core iexs_core_inst (
    .clk(clk), .rst_n(rst_n), .issue(issue), .op(op), .imm(imm), .jump_addr(jump_addr),
    .mem_rdata(mem_rdata), .stack_top(stack_top), .wake(wake), .busy(busy), .mem_we(mem_we),
    .mem_wdata(mem_wdata), .pc(pc), .stack_pop(stack_pop), .sys_clk_en(sys_clk_en),
    .watchdog_clear(watchdog_clear), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata)
  );

  always #5 clk = ~clk;

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // bounded run: a hung sequence ends as a mismatch
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      give_verdict();
    end
  end

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic exec(input iexs_op_t o, input logic [7:0] i, m);
    @(posedge clk);
    issue     <= 1'b1;
    op        <= o;
    imm       <= i;
    mem_rdata <= m;
    @(posedge clk);
    issue     <= 1'b0;
    #1 got_we = mem_we;
    got_wd = mem_wdata;
  endtask

  // status compared on carry, half-carry, zero, powerdown
  task automatic run(input iexs_op_t o, input logic [7:0] i, m, input logic we, input logic [7:0] wd, wa, st);
    exec(o, i, m);
    pc_exp = pc_exp + PC_STEP;
    `CHK("mem_we", we, got_we)
    if (we) `CHK("mem_wdata", wd, got_wd)
    `CHK("pc", pc_exp, pc)
    rd(RIDX_WREG, v);
    `CHK("work_register", wa, v)
    rd(RIDX_STATUS, v);
    `CHK("status", st, v & 8'h27)
  endtask

  // a NOP is offered in the busy cycle and must be ignored
  task automatic ret_op(input iexs_op_t o, input logic [7:0] i, input logic [PC_W-1:0] t);
    @(posedge clk);
    issue     <= 1'b1;
    op        <= o;
    imm       <= i;
    stack_top <= t;
    @(posedge clk);
    op        <= IEXS_OP_NOP;
    #1 `CHK("busy", 1'b1, busy)
    @(posedge clk);
    issue     <= 1'b0;
    #1 `CHK("pc", t, pc)
    `CHK("stack_pop", 1'b1, stack_pop)
    `CHK("busy", 1'b0, busy)
    pc_exp = t;
  endtask

  initial begin
    clk = 1'b0; rst_n = 1'b0; issue = 1'b0; wake = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0;
    op = IEXS_OP_NOP; imm = 8'h00; mem_rdata = 8'h00; reg_wdata = 8'h00; reg_addr = 3'h0;
    jump_addr = 13'h0000; stack_top = 13'h0000; num_errors = 0; n_checks = 0; cyc = 0;
    pc_exp = PC_RST;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(RIDX_STATUS, v);
    `CHK("status_rst", 8'h00, v & 8'h37)
    `CHK("sys_clk_en", 1'b1, sys_clk_en)
    wr(RIDX_WREG, 8'h5A);
    rd(RIDX_WREG, v);
    `CHK("work_register", 8'h5A, v)
    $display("test reset_and_port done");
    run(IEXS_OP_MOV_AM, 8'h00, 8'h00, 1'b0, 8'h00, 8'h00, 8'h00);
    run(IEXS_OP_INC, 8'h00, 8'hFF, 1'b1, 8'h00, 8'h00, 8'h04);
    run(IEXS_OP_MOV_AX, 8'h45, 8'h00, 1'b0, 8'h00, 8'h45, 8'h04);
    run(IEXS_OP_MOV_MA, 8'h00, 8'h00, 1'b1, 8'h45, 8'h45, 8'h04);
    run(IEXS_OP_DEC, 8'h00, 8'h80, 1'b1, 8'h7F, 8'h45, 8'h00);
    run(IEXS_OP_DECA, 8'h00, 8'h01, 1'b0, 8'h00, 8'h00, 8'h04);
    wr(RIDX_STATUS, 8'h00);
    run(IEXS_OP_OR_AM, 8'h00, 8'h00, 1'b0, 8'h00, 8'h00, 8'h04);
    run(IEXS_OP_INCA, 8'h00, 8'h7F, 1'b0, 8'h00, 8'h80, 8'h00);
    run(IEXS_OP_OR_AX, 8'h01, 8'h00, 1'b0, 8'h00, 8'h81, 8'h00);
    run(IEXS_OP_ORM, 8'h00, 8'h42, 1'b1, 8'hC3, 8'h81, 8'h00);
    $display("test move_incdec_or done");
    run(IEXS_OP_RL, 8'h00, 8'h81, 1'b1, 8'h03, 8'h81, 8'h00);
    run(IEXS_OP_RLA, 8'h00, 8'h40, 1'b0, 8'h00, 8'h80, 8'h00);
    run(IEXS_OP_RLCM, 8'h00, 8'h80, 1'b1, 8'h00, 8'h80, 8'h01);
    run(IEXS_OP_RLCA, 8'h00, 8'h01, 1'b0, 8'h00, 8'h03, 8'h00);
    run(IEXS_OP_MOV_AX, 8'h9A, 8'h00, 1'b0, 8'h00, 8'h9A, 8'h00);
    run(IEXS_OP_BCDADJ, 8'h00, 8'h00, 1'b1, 8'h00, 8'h9A, 8'h01);
    run(IEXS_OP_MOV_AX, 8'h12, 8'h00, 1'b0, 8'h00, 8'h12, 8'h01);
    run(IEXS_OP_BCDADJ, 8'h00, 8'h00, 1'b1, 8'h72, 8'h12, 8'h01);
    wr(RIDX_STATUS, 8'h00);
    run(IEXS_OP_MOV_AX, 8'h38, 8'h00, 1'b0, 8'h00, 8'h38, 8'h00);
    run(IEXS_OP_BCDADJ, 8'h00, 8'h00, 1'b1, 8'h38, 8'h38, 8'h00);
    wr(RIDX_STATUS, 8'h02);
    run(IEXS_OP_BCDADJ, 8'h00, 8'h00, 1'b1, 8'h3E, 8'h38, 8'h02);
    wr(RIDX_STATUS, 8'h00);
    run(IEXS_OP_NOP, 8'h00, 8'h00, 1'b0, 8'h00, 8'h38, 8'h00);
    $display("test rotate_adjust done");
    @(posedge clk);
    jump_addr <= 13'h1A5C;
    exec(IEXS_OP_JMP, 8'h00, 8'h00);
    `CHK("pc_jump", 13'h1A5C, pc)
    rd(RIDX_PCLO, v);
    `CHK("pc_low", 8'h5C, v)
    rd(RIDX_PCHI, v);
    `CHK("pc_high", 8'h1A, v)
    ret_op(IEXS_OP_RET, 8'h00, 13'h0123);
    ret_op(IEXS_OP_RETV, 8'hA7, 13'h1FFE);
    rd(RIDX_WREG, v);
    `CHK("work_register", 8'hA7, v)
    ret_op(IEXS_OP_IRQRET, 8'h00, 13'h0040);
    rd(RIDX_IRQCTL, v);
    `CHK("irq_enable", 1'b1, v[IRQ_EN_BIT])
    rd(RIDX_STATUS, v);
    `CHK("status", 8'h00, v & 8'h27)
    $display("test jump_return done");
    // let the watchdog count up so the halt clear is visible
    repeat (300) @(posedge clk);
    exec(IEXS_OP_HALT, 8'h00, 8'h00);
    pc_exp = 13'h0041;
    `CHK("sys_clk_en", 1'b0, sys_clk_en)
    `CHK("busy", 1'b1, busy)
    `CHK("watchdog_clear", 1'b1, watchdog_clear)
    `CHK("pc", pc_exp, pc)
    @(posedge clk);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    #1 `CHK("sys_clk_en", 1'b1, sys_clk_en)
    rd(RIDX_STATUS, v);
    `CHK("status", 8'h20, v & 8'h37)
    rd(RIDX_WREG, v);
    `CHK("work_register", 8'hA7, v)
    rd(RIDX_WATCHDOG, v);
    `CHK("watchdog", 8'h00, v)
    $display("test halt done");
    give_verdict();
  end
endmodule // instruction_exec_subset_bench
